// ===== common/an_regs_pkg.sv
// Constants for the negotiation management register set
package an_regs_pkg;
  // ----------------------------------------
  // Access port
  // ----------------------------------------
  localparam logic [4:0]  UNIT_ADDR    = 5'h07;   // Management unit address
  localparam logic [15:0] OFS_UNITS_HI = 16'h0006; // Units-present map, high
  localparam logic [15:0] OFS_CTRL     = 16'h0200; // Negotiation control
  localparam logic [15:0] OFS_STAT     = 16'h0201; // Negotiation status
  localparam logic [15:0] OFS_ADV_LO   = 16'h0202; // Local advertisement, low
  // ----------------------------------------
  // Values after reset and fixed values
  // ----------------------------------------
  localparam logic [15:0] UNITS_HI_VAL = 16'hC000; // Both vendor units present
  localparam logic [15:0] CTRL_RST     = 16'h1000;
  localparam logic [15:0] STAT_RST     = 16'h0008;
  localparam logic [15:0] ADV_RST      = 16'h0001;
  localparam logic [4:0]  SELECTOR_VAL = 5'h01;   // Ethernet selector
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_EN_BIT   = 12;
  localparam int CTRL_RST_BIT  = 9;
  localparam int STAT_PAGE_BIT = 6;
  localparam int STAT_DONE_BIT = 5;
  localparam int STAT_FLT_BIT  = 4;
  localparam int STAT_ABLE_BIT = 3;
  localparam int STAT_LINK_BIT = 2;
  localparam int ADV_NP_BIT    = 15;
  localparam int ADV_ACK_BIT   = 14;
  localparam int ADV_FLT_BIT   = 13;
  localparam int ADV_FORCE_BIT = 12;
  localparam int ADV_PAUSE_HI  = 11;
  localparam int ADV_PAUSE_LO  = 10;
  localparam int ADV_SEL_HI    = 4;
endpackage

// ===== src/an_regs.sv
// Negotiation management register set with latching status flags
//
// Contract
// - Units map reads fixed C000, read-only
// - Control bit 12 enables negotiation, resets 1
// - Restart bit reads 1 until initiated
// - Page received sets; status read clears
// - Partner ability valid from first page
// - Done needs finish, link, valid abilities
// - Done reads 0 while negotiation disabled
// - Partner fault latches high until read
// - Status bit 3 always reads 1
// - Link bit latches low until read
// - Advert bit 15 requests next page
// - Acknowledge bit set on codeword receipt
// - Advert bit 13 carries local fault
// - Advert bit 12 forces role choice
// - Advert bits 11:10 advertise pause
// - Selector fixed 00001, read-only
// - Role bit: 0 follower, 1 leader
`timescale 1ns/1ps
module an_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register access port
  input  wire logic        reg_req,
  input  wire logic        reg_we,
  input  wire logic [4:0]  reg_unit,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_ack,
  // Events from the negotiation engine
  input  wire logic        page_stored,
  input  wire logic        base_page_fault,
  input  wire logic        restart_taken,
  input  wire logic        engine_finished,
  input  wire logic        link_ok,
  // Role strap pin
  input  wire logic        role_strap,
  // Controls to the negotiation engine
  output logic             negotiation_enable,
  output logic             restart_request,
  output logic      [15:0] base_advert_word,
  output logic             role_leader_pref,
  output logic             force_role_select
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire unit_hit = reg_req && (reg_unit == an_regs_pkg::UNIT_ADDR);
  wire hit_map  = unit_hit && (reg_addr == an_regs_pkg::OFS_UNITS_HI);
  wire hit_ctrl = unit_hit && (reg_addr == an_regs_pkg::OFS_CTRL);
  wire hit_stat = unit_hit && (reg_addr == an_regs_pkg::OFS_STAT);
  wire hit_adv  = unit_hit && (reg_addr == an_regs_pkg::OFS_ADV_LO);
  wire wr_ctrl  = hit_ctrl && reg_we;
  wire wr_adv   = hit_adv && reg_we;
  wire rd_stat  = hit_stat && !reg_we;

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  logic       en_r;          // Negotiation enable
  logic       restart_r;     // Pending restart
  logic       page_r;        // Page received, latched high
  logic       fault_r;       // Partner fault, latched high
  logic       link_r;        // Link status, latched low
  logic       lp_valid_r;    // Partner ability holds valid contents
  logic       ack_r;         // Codeword acknowledge
  logic       np_r;          // Next page request
  logic       lflt_r;        // Local fault advert
  logic       force_r;       // Forced role
  logic [1:0] pause_r;       // Pause advert
  logic       strap_s1_r;    // Strap synchroniser, first stage
  logic       strap_s2_r;    // Strap synchroniser, second stage
  logic       role_r;        // Captured role preference
  logic [15:0] rdata_r;      // Read data
  logic       ack_out_r;     // Access acknowledge

  // Restart applies only to this cycle's write
  wire wr_restart = wr_ctrl && reg_wdata[an_regs_pkg::CTRL_RST_BIT];
  // Disabling or restarting ends the present negotiation
  wire neg_reset  = !en_r || restart_taken;

  // ----------------------------------------
  // Assembled register images
  // ----------------------------------------
  wire done_now = en_r && engine_finished && link_ok && lp_valid_r;

  logic [15:0] ctrl_img;
  logic [15:0] stat_img;
  logic [15:0] adv_img;
  always_comb begin
    ctrl_img = 16'h0000;
    ctrl_img[an_regs_pkg::CTRL_EN_BIT]  = en_r;
    ctrl_img[an_regs_pkg::CTRL_RST_BIT] = restart_r;
  end
  always_comb begin
    stat_img = 16'h0000;
    stat_img[an_regs_pkg::STAT_PAGE_BIT] = page_r;
    stat_img[an_regs_pkg::STAT_DONE_BIT] = done_now;
    stat_img[an_regs_pkg::STAT_FLT_BIT]  = fault_r;
    stat_img[an_regs_pkg::STAT_ABLE_BIT] = 1'b1;
    stat_img[an_regs_pkg::STAT_LINK_BIT] = link_r;
  end
  always_comb begin
    adv_img = 16'h0000;
    adv_img[an_regs_pkg::ADV_NP_BIT]    = np_r;
    adv_img[an_regs_pkg::ADV_ACK_BIT]   = ack_r;
    adv_img[an_regs_pkg::ADV_FLT_BIT]   = lflt_r;
    adv_img[an_regs_pkg::ADV_FORCE_BIT] = force_r;
    adv_img[an_regs_pkg::ADV_PAUSE_HI:an_regs_pkg::ADV_PAUSE_LO] = pause_r;
    adv_img[an_regs_pkg::ADV_SEL_HI:0] = an_regs_pkg::SELECTOR_VAL;
  end

  // Read mux; unmapped or other-unit addresses read zero
  wire [15:0] rd_mux = hit_map  ? an_regs_pkg::UNITS_HI_VAL :
                       hit_ctrl ? ctrl_img :
                       hit_stat ? stat_img :
                       hit_adv  ? adv_img  : 16'h0000;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Enable is plain read/write; software is expected to leave it set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_r <= an_regs_pkg::CTRL_RST[an_regs_pkg::CTRL_EN_BIT];
    end else if (wr_ctrl) begin
      en_r <= reg_wdata[an_regs_pkg::CTRL_EN_BIT];
    end
  end

  // Restart holds until the engine takes it; a new write wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_r <= an_regs_pkg::CTRL_RST[an_regs_pkg::CTRL_RST_BIT];
    end else if (wr_restart) begin
      restart_r <= 1'b1;
    end else if (restart_taken) begin
      restart_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Latching status flags
  // ----------------------------------------
  // Latched-high flags: an event in the read cycle survives the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_r  <= an_regs_pkg::STAT_RST[an_regs_pkg::STAT_PAGE_BIT];
      fault_r <= an_regs_pkg::STAT_RST[an_regs_pkg::STAT_FLT_BIT];
    end else begin
      page_r  <= page_stored || (page_r && !rd_stat);
      fault_r <= base_page_fault || (fault_r && !rd_stat);
    end
  end

  // Latched-low link: a read reloads the present link level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_r <= an_regs_pkg::STAT_RST[an_regs_pkg::STAT_LINK_BIT];
    end else if (rd_stat) begin
      link_r <= link_ok;
    end else begin
      link_r <= link_r && link_ok;
    end
  end

  // Partner contents valid and acknowledge from first stored page
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lp_valid_r <= 1'b0;
      ack_r      <= an_regs_pkg::ADV_RST[an_regs_pkg::ADV_ACK_BIT];
    end else if (neg_reset) begin
      lp_valid_r <= 1'b0;
      ack_r      <= 1'b0;
    end else if (page_stored) begin
      lp_valid_r <= 1'b1;
      ack_r      <= 1'b1;
    end
  end

  // ----------------------------------------
  // Advertisement register
  // ----------------------------------------
  // Only the writable fields store; acknowledge and selector ignore writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      np_r    <= an_regs_pkg::ADV_RST[an_regs_pkg::ADV_NP_BIT];
      lflt_r  <= an_regs_pkg::ADV_RST[an_regs_pkg::ADV_FLT_BIT];
      force_r <= an_regs_pkg::ADV_RST[an_regs_pkg::ADV_FORCE_BIT];
      pause_r <= an_regs_pkg::ADV_RST[an_regs_pkg::ADV_PAUSE_HI:an_regs_pkg::ADV_PAUSE_LO];
    end else if (wr_adv) begin
      np_r    <= reg_wdata[an_regs_pkg::ADV_NP_BIT];
      lflt_r  <= reg_wdata[an_regs_pkg::ADV_FLT_BIT];
      force_r <= reg_wdata[an_regs_pkg::ADV_FORCE_BIT];
      pause_r <= reg_wdata[an_regs_pkg::ADV_PAUSE_HI:an_regs_pkg::ADV_PAUSE_LO];
    end
  end

  // ----------------------------------------
  // Role strap
  // ----------------------------------------
  // Two-stage synchroniser, then one more register that follows it as the role preference
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      role_r     <= 1'b0;
    end else begin
      strap_s1_r <= role_strap;
      strap_s2_r <= strap_s1_r;
      role_r     <= strap_s2_r;
    end
  end

  // ----------------------------------------
  // Access answer
  // ----------------------------------------
  // Every request answers one cycle later; reads carry the pre-clear image, writes read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r   <= 16'h0000;
      ack_out_r <= 1'b0;
    end else begin
      ack_out_r <= reg_req;
      rdata_r   <= (reg_req && !reg_we) ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata          = rdata_r;
  assign reg_ack            = ack_out_r;
  assign negotiation_enable = en_r;
  assign restart_request    = restart_r;
  assign base_advert_word   = adv_img;
  assign role_leader_pref   = role_r;
  assign force_role_select  = force_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_map_read;
    hit_map && !reg_we;
  endsequence

  a_map_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    s_map_read |=> reg_rdata == 16'hC000)
    else $error("units map read wrong");

  a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl |=> negotiation_enable == $past(reg_wdata[12]))
    else $error("enable bit not stored");

  a_restart_hold: assert property (@(posedge clk) disable iff (!rst_n)
    wr_restart |=> restart_request until_with (restart_taken || wr_restart))
    else $error("restart cleared early");

  a_restart_clear: assert property (@(posedge clk) disable iff (!rst_n)
    restart_taken && !wr_restart |=> !restart_request)
    else $error("restart not cleared");

  a_page_set: assert property (@(posedge clk) disable iff (!rst_n)
    page_stored ##1 (rd_stat && !reg_we) |=> reg_rdata[6])
    else $error("page flag lost");

  a_page_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stat && !page_stored ##1 (rd_stat && !page_stored) |=> !reg_rdata[6])
    else $error("page flag not cleared by read");

  a_done_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_req && !reg_we && hit_stat && !en_r) |=> !reg_rdata[5])
    else $error("done set while disabled");

  a_able_one: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stat |=> reg_rdata[3])
    else $error("capable bit low");

  a_link_low: assert property (@(posedge clk) disable iff (!rst_n)
    !link_ok ##1 (rd_stat [*1]) |=> !reg_rdata[2])
    else $error("link drop not latched");

  a_selector_fix: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 base_advert_word[4:0] == 5'h01 && $stable(base_advert_word[4:0]))
    else $error("selector changed");

  a_ack_page: assert property (@(posedge clk) disable iff (!rst_n)
    page_stored && !neg_reset |=> base_advert_word[14] [*2] or restart_taken or !negotiation_enable)
    else $error("acknowledge not set");

  // A partner fault must still be reported by a first status read that comes three cycles after it
  a_fault_hold: assert property (@(posedge clk) disable iff (!rst_n)
    base_page_fault ##1 (!rd_stat [*2]) ##1 rd_stat |=> reg_rdata[4])
    else $error("fault flag lost");

  // Pause field takes the written value
  a_advert_store: assert property (@(posedge clk) disable iff (!rst_n)
    wr_adv |=> base_advert_word[11:10] == $past(reg_wdata[11:10]))
    else $error("pause advert not stored");

endmodule

// ===== verif/eng_model.sv
// Negotiation engine stand-in that stores partner pages and honours restarts
`timescale 1ns/1ps
module eng_model #(
  parameter int RESTART_DLY = 6 // Wait count at which a restart is taken, RESTART_DLY+1 cycles after the request rises
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Commands from the bench
  input  wire logic cmd_page,
  input  wire logic cmd_fault,
  // Control from the block
  input  wire logic restart_request,
  // Events to the block
  output logic      page_stored,
  output logic      base_page_fault,
  output logic      restart_taken
);
  logic [7:0] wait_r; // Restart wait counter
  // ----------------------------------------
  // Event pulses
  // ----------------------------------------
  // A slow engine: the restart stays pending for a while, so it can be seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_stored     <= 1'b0;
      base_page_fault <= 1'b0;
      restart_taken   <= 1'b0;
      wait_r          <= 8'h00;
    end else begin
      page_stored     <= cmd_page;
      base_page_fault <= cmd_page & cmd_fault;
      restart_taken   <= 1'b0;
      if (restart_request && !restart_taken) begin
        wait_r <= wait_r + 8'h01;
        if (wait_r == RESTART_DLY[7:0]) begin
          restart_taken <= 1'b1;
          wait_r        <= 8'h00;
        end
      end
    end
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the negotiation register set
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, rst_n, reg_req, reg_we, engine_finished, link_ok, role_strap;
  logic [4:0]  reg_unit;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, base_advert_word, rd;
  logic        reg_ack, page_stored, base_page_fault, restart_taken, cmd_page, cmd_fault;
  logic        negotiation_enable, restart_request, role_leader_pref, force_role_select;
  int          mismatches, cmp_count;
  // ----------------------------------------
  // Design and engine stand-in
  // ----------------------------------------
  an_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_we(reg_we), .reg_unit(reg_unit),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .page_stored(page_stored), .base_page_fault(base_page_fault), .restart_taken(restart_taken),
    .engine_finished(engine_finished), .link_ok(link_ok), .role_strap(role_strap),
    .negotiation_enable(negotiation_enable), .restart_request(restart_request),
    .base_advert_word(base_advert_word), .role_leader_pref(role_leader_pref),
    .force_role_select(force_role_select));
  eng_model u_eng (.clk(clk), .rst_n(rst_n), .cmd_page(cmd_page), .cmd_fault(cmd_fault),
    .restart_request(restart_request), .page_stored(page_stored),
    .base_page_fault(base_page_fault), .restart_taken(restart_taken));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Compares one value and counts it
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One access, entered just after an edge; answer taken one cycle later
  task automatic acc(input logic we, input logic [4:0] un, input logic [15:0] ad, input logic [15:0] wd);
    reg_req   = 1'b1;
    reg_we    = we;
    reg_unit  = un;
    reg_addr  = ad;
    reg_wdata = wd;
    @(posedge clk); #1;
    reg_req = 1'b0;
    chk("ack", 16'h0001, {15'h0000, reg_ack});
    rd = reg_rdata;
    @(posedge clk); #1;
  endtask
  // Reads a register of the unit and compares it
  task automatic rchk(input string nm, input logic [15:0] ad, input logic [15:0] exp);
    acc(1'b0, an_regs_pkg::UNIT_ADDR, ad, 16'h0000);
    chk(nm, exp, rd);
  endtask
  // Partner page stored by the engine
  task automatic page(input logic flt);
    cmd_page  = 1'b1;
    cmd_fault = flt;
    @(posedge clk); #1;
    cmd_page = 1'b0;
    @(posedge clk); #1;
  endtask
  // Ends the run with the verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset images and fixed fields
  task automatic t_reset();
    rchk("units_map", an_regs_pkg::OFS_UNITS_HI, 16'hC000);
    rchk("control", an_regs_pkg::OFS_CTRL, 16'h1000);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h0008);
    rchk("advert", an_regs_pkg::OFS_ADV_LO, 16'h0001);
    $display("test reset done");
  endtask
  // Writable and read-only fields, refused places
  task automatic t_write();
    acc(1'b1, an_regs_pkg::UNIT_ADDR, an_regs_pkg::OFS_UNITS_HI, 16'h1234);
    rchk("units_map", an_regs_pkg::OFS_UNITS_HI, 16'hC000);
    acc(1'b1, an_regs_pkg::UNIT_ADDR, an_regs_pkg::OFS_ADV_LO, 16'hFFFF);
    rchk("advert", an_regs_pkg::OFS_ADV_LO, 16'hBC01);
    chk("advert_word", 16'hBC01, base_advert_word);
    chk("force_role", 16'h0001, {15'h0000, force_role_select});
    acc(1'b1, an_regs_pkg::UNIT_ADDR, an_regs_pkg::OFS_ADV_LO, 16'h0001);
    chk("advert_word", 16'h0001, base_advert_word);
    rchk("unmapped", 16'h0203, 16'h0000);
    acc(1'b0, 5'h03, an_regs_pkg::OFS_UNITS_HI, 16'h0000);
    chk("other_unit", 16'h0000, rd);
    $display("test write done");
  endtask
  // Page, fault, completion and disable
  task automatic t_events();
    link_ok = 1'b1;
    rchk("status", an_regs_pkg::OFS_STAT, 16'h0008);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h000C);
    page(1'b1);
    rchk("advert", an_regs_pkg::OFS_ADV_LO, 16'h4001);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h005C);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h000C);
    engine_finished = 1'b1;
    rchk("status", an_regs_pkg::OFS_STAT, 16'h002C);
    acc(1'b1, an_regs_pkg::UNIT_ADDR, an_regs_pkg::OFS_CTRL, 16'h0000);
    chk("enable", 16'h0000, {15'h0000, negotiation_enable});
    rchk("status", an_regs_pkg::OFS_STAT, 16'h000C);
    acc(1'b1, an_regs_pkg::UNIT_ADDR, an_regs_pkg::OFS_CTRL, 16'h1000);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h000C);
    page(1'b0);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h006C);
    $display("test events done");
  endtask
  // Link drop latched, and a page landing during a status read
  task automatic t_latch();
    link_ok = 1'b0;
    @(posedge clk); #1;
    link_ok = 1'b1;
    rchk("status", an_regs_pkg::OFS_STAT, 16'h0028);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h002C);
    cmd_page = 1'b1;
    @(posedge clk); #1;
    cmd_page = 1'b0;
    rchk("status", an_regs_pkg::OFS_STAT, 16'h002C);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h006C);
    // Two status reads back to back: the first clears, the second sees it cleared
    page(1'b0);
    reg_req  = 1'b1;
    reg_we   = 1'b0;
    reg_unit = an_regs_pkg::UNIT_ADDR;
    reg_addr = an_regs_pkg::OFS_STAT;
    @(posedge clk); #1;
    chk("status", 16'h006C, reg_rdata);
    @(posedge clk); #1;
    reg_req = 1'b0;
    chk("status", 16'h002C, reg_rdata);
    @(posedge clk); #1;
    $display("test latch done");
  endtask
  // Restart pending until taken, then self-clearing
  task automatic t_restart();
    int n;
    acc(1'b1, an_regs_pkg::UNIT_ADDR, an_regs_pkg::OFS_CTRL, 16'h1200);
    rchk("control", an_regs_pkg::OFS_CTRL, 16'h1200);
    chk("restart_req", 16'h0001, {15'h0000, restart_request});
    n = 0;
    while (restart_request !== 1'b0 && n < 40) begin
      @(posedge clk); #1;
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      $display("unexpected restart_request expected 0 seen 1");
      report_and_stop();
    end
    rchk("control", an_regs_pkg::OFS_CTRL, 16'h1000);
    rchk("status", an_regs_pkg::OFS_STAT, 16'h000C);
    $display("test restart done");
  endtask
  // Role taken from the strap
  task automatic t_role();
    role_strap = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("role", 16'h0001, {15'h0000, role_leader_pref});
    $display("test role done");
  endtask
  // ----------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    mismatches      = 0;
    cmp_count       = 0;
    rst_n           = 1'b0;
    reg_req         = 1'b0;
    reg_we          = 1'b0;
    reg_unit        = 5'h00;
    reg_addr        = 16'h0000;
    reg_wdata       = 16'h0000;
    engine_finished = 1'b0;
    link_ok         = 1'b0;
    role_strap      = 1'b0;
    cmd_page        = 1'b0;
    cmd_fault       = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_write();
    t_events();
    t_latch();
    t_restart();
    t_role();
    report_and_stop();
  end
endmodule
